// File: pcc_card_config_regs.sv
// Card and logical device configuration registers behind an AHB-Lite slave
//
// Behaviour
// [R1] Soft-reset bit resets logical devices to defaults, keeps card select number
// [R2] Configuration control bits clear themselves after every write
// [R3] Control bit 1 is the return to Wait for Key command
// [R4] Wait for Key command keeps card select number and logical devices
// [R5] Control bit 2 clears the card select number to zero
// [R6] Wake with matching number leaves Sleep: zero to Isolation, else Config
// [R7] Every wake write restarts the resource byte stream
// [R8] Software polls status bit 0 before each resource data read
// [R9] Status bit 0 is one when the next resource byte is ready
// [R10] Each resource data read returns the next byte of the stream; after the 16th byte the code returns the 16th byte again
// [R11] Card select number register stores writes and reads them back
// [R12] Logical device number selects which device's registers are accessed
// [R13] Activation bit 0 makes the selected device respond on the bus
// [R14] Software disables range checking before activating a device
// [R15] Enabled range check answers reads with 0055h or 00AAh per bit 0
// [R16] Range check answers only while the device is inactive
// [R17] Reserved activation and range check bits read as zero
// [R18] Two I/O base descriptors, high and low bytes, per device
// [R19] Writes to read-only and reads of write-only registers change nothing
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module pcc_card_config_regs
	import pcc_pkg::*;
(
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RST,
	// AHB-Lite slave
	input  wire logic                HSEL,
	input  wire logic [31:0]         HADDR,
	input  wire logic [1:0]          HTRANS,
	input  wire logic                HWRITE,
	input  wire logic [2:0]          HSIZE,
	input  wire logic [31:0]         HWDATA,
	input  wire logic                HREADY,
	output logic                     HREADYOUT,
	output logic                     HRESP,
	output logic [31:0]              HRDATA,
	// ISA I/O read pins
	input  wire logic                IO_RD_N,
	input  wire logic [15:0]         IO_ADDR,
	output logic [15:0]              IO_DATA,
	output logic                     IO_DATA_OE,
	// Card status
	output logic [NUM_LDEV-1:0]      DEV_ACTIVE,
	output logic [3:0]               CARD_STATE
);

	typedef struct packed {
		pcc_card_state_t             st;
		logic [7:0]                  card_select_number;
		logic [7:0]                  ldn;
		pcc_ldev_t [NUM_LDEV-1:0]    dev;
		logic                        dp_wr;
		logic                        dp_rd;
		logic [7:0]                  dp_idx;
		logic                        hready;
		logic [31:0]                 hrdata;
		pcc_isa_in_t                 isa1;
		pcc_isa_in_t                 isa2;
		pcc_isa_in_t                 isa3;
		pcc_isa_in_t                 isa_f;
		logic [15:0]                 io_data;
		logic                        io_oe;
		logic [NUM_LDEV-1:0]         active;
	} pcc_top_state_t;

	localparam pcc_top_state_t TOP_RESET = '{
		st:     PCC_WAIT_KEY,
		hready: 1'b1,
		isa1:   ISA_IDLE,
		isa2:   ISA_IDLE,
		isa3:   ISA_IDLE,
		isa_f:  ISA_IDLE,
		default: '0
	};

	pcc_top_state_t q;
	pcc_top_state_t next_q;

	logic           res_restart;
	logic           res_advance;
	logic           res_ready;
	logic [7:0]     res_data;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// I/O address falls in the range starting at a base
	function automatic logic io_hit(input logic [15:0] addr, input logic [15:0] base);
		io_hit = (addr[15:IO_DEC_LSB] == base[15:IO_DEC_LSB]);
	endfunction : io_hit

	// Selected logical device exists
	function automatic logic ldn_ok(input logic [7:0] ldn);
		ldn_ok = (ldn < 8'(NUM_LDEV));
	endfunction : ldn_ok

	////////////////////////////////////////////////////////////////////////
	// Resource byte stream

	pcc_resource_stream u_res (
		.clk     (CLK),
		.rst     (RST),
		.restart (res_restart),
		.advance (res_advance),
		.ready   (res_ready),
		.data    (res_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Register read decode

	logic [7:0]       rd_val;
	logic [LDEV_W-1:0] sel;
	pcc_ldev_t        sel_dev;

	always_comb
	begin
		sel     = q.ldn[LDEV_W-1:0];
		sel_dev = q.dev[sel];
		rd_val  = RST_BYTE;
		unique case (q.dp_idx)
			IDX_RES_DATA:
				rd_val = res_data;                                // [R10]
			IDX_STATUS:
				rd_val = {7'h00, res_ready};                      // [R9]
			IDX_CSN:
				rd_val = q.card_select_number;                                   // [R11]
			IDX_LDN:
				rd_val = q.ldn;                                   // [R12]
			IDX_ACTIVATE:
			begin
				if (ldn_ok(q.ldn))
					rd_val = {7'h00, sel_dev.act};                // [R17]
			end
			IDX_RANGE_CHK:
			begin
				if (ldn_ok(q.ldn))
					rd_val = {6'h00, sel_dev.chk};                // [R17]
			end
			IDX_BASE0_HI:
			begin
				if (ldn_ok(q.ldn))
					rd_val = sel_dev.base0[15:8];                 // [R18]
			end
			IDX_BASE0_LO:
			begin
				if (ldn_ok(q.ldn))
					rd_val = sel_dev.base0[7:0];                  // [R18]
			end
			IDX_BASE1_HI:
			begin
				if (ldn_ok(q.ldn))
					rd_val = sel_dev.base1[15:8];                 // [R18]
			end
			IDX_BASE1_LO:
			begin
				if (ldn_ok(q.ldn))
					rd_val = sel_dev.base1[7:0];                  // [R18]
			end
			default:
				rd_val = RST_BYTE;                                // [R19]
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	logic       addr_take;
	logic [7:0] wd;

	always_comb
	begin
		next_q      = q;
		res_restart = 1'b0;
		res_advance = 1'b0;
		wd          = HWDATA[7:0];
		addr_take   = HSEL && HREADY && HTRANS[1];

		// Address phase
		next_q.dp_wr  = addr_take && HWRITE;
		next_q.dp_rd  = addr_take && !HWRITE;
		next_q.hready = !(addr_take && !HWRITE);
		if (addr_take)
			next_q.dp_idx = HADDR[IDX_MSB:IDX_LSB];

		// Read data phase
		if (q.dp_rd)
		begin
			next_q.hrdata = {24'h00_0000, rd_val};
			if (q.dp_idx == IDX_RES_DATA)
				res_advance = 1'b1;                               // [R10]
		end

		// Write data phase
		if (q.dp_wr)
		begin
			unique case (q.dp_idx)
				IDX_CFG_CTRL:
				begin
					if (wd[CTRL_SOFT_RST])
					begin
						for (int i = 0; i < NUM_LDEV; i++)
							next_q.dev[i] = '0;                   // [R1]
						next_q.ldn = RST_BYTE;                    // [R1]
					end
					if (wd[CTRL_WAIT_KEY])
						next_q.st = PCC_WAIT_KEY;                 // [R3] [R4]
					if (wd[CTRL_CLR_CSN])
						next_q.card_select_number = RST_BYTE;                    // [R5]
				end
				IDX_WAKE:
				begin
					res_restart = 1'b1;                           // [R7]
					if (wd == q.card_select_number)
					begin
						if (q.st == PCC_SLEEP)
							next_q.st = (wd == RST_BYTE) ? PCC_ISOL : PCC_CONFIG; // [R6]
					end
					else if (q.st == PCC_ISOL || q.st == PCC_CONFIG)
						next_q.st = PCC_SLEEP;
				end
				IDX_CSN:
				begin
					next_q.card_select_number = wd;                              // [R11]
					if (q.st == PCC_ISOL)
						next_q.st = PCC_CONFIG;
				end
				IDX_LDN:
					next_q.ldn = wd;                              // [R12]
				IDX_KEY_ENTER:
				begin
					if (q.st == PCC_WAIT_KEY)
						next_q.st = PCC_SLEEP;
				end
				IDX_ACTIVATE:
				begin
					if (ldn_ok(q.ldn))
						next_q.dev[sel].act = wd[ACT_BIT];        // [R12] [R13]
				end
				IDX_RANGE_CHK:
				begin
					if (ldn_ok(q.ldn))
						next_q.dev[sel].chk = wd[CHK_EN_BIT:CHK_PASS_BIT]; // [R12]
				end
				IDX_BASE0_HI:
				begin
					if (ldn_ok(q.ldn))
						next_q.dev[sel].base0[15:8] = wd;         // [R18]
				end
				IDX_BASE0_LO:
				begin
					if (ldn_ok(q.ldn))
						next_q.dev[sel].base0[7:0] = wd;          // [R18]
				end
				IDX_BASE1_HI:
				begin
					if (ldn_ok(q.ldn))
						next_q.dev[sel].base1[15:8] = wd;         // [R18]
				end
				IDX_BASE1_LO:
				begin
					if (ldn_ok(q.ldn))
						next_q.dev[sel].base1[7:0] = wd;          // [R18]
				end
				default:
					next_q.card_select_number = q.card_select_number;                           // [R2] [R19]
			endcase
		end

		// ISA pin synchroniser, change counts when stages two and three agree
		next_q.isa1 = '{rd_n: IO_RD_N, addr: IO_ADDR};
		next_q.isa2 = q.isa1;
		next_q.isa3 = q.isa2;
		if (q.isa2 == q.isa3)
			next_q.isa_f = q.isa3;

		// Range check answer, lowest device wins
		next_q.io_oe   = 1'b0;
		next_q.io_data = IO_ZERO;
		if (!q.isa_f.rd_n)
		begin
			for (int i = NUM_LDEV - 1; i >= 0; i--)
			begin
				if (!q.dev[i].act && q.dev[i].chk[CHK_EN_BIT] &&
				    (io_hit(q.isa_f.addr, q.dev[i].base0) ||
				     io_hit(q.isa_f.addr, q.dev[i].base1)))       // [R16]
				begin
					next_q.io_oe   = 1'b1;
					next_q.io_data = q.dev[i].chk[CHK_PASS_BIT] ? RC_PASS : RC_FAIL; // [R15]
				end
			end
		end

		// Activation outputs
		for (int i = 0; i < NUM_LDEV; i++)
			next_q.active[i] = q.dev[i].act;                      // [R13]
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge CLK)
	begin
		if (RST)
			q <= TOP_RESET;
		else
			q <= next_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign HREADYOUT  = q.hready;
	assign HRESP      = HRESP_OKAY;
	assign HRDATA     = q.hrdata;
	assign IO_DATA    = q.io_data;
	assign IO_DATA_OE = q.io_oe;
	assign DEV_ACTIVE = q.active;
	assign CARD_STATE = q.st;

endmodule : pcc_card_config_regs

// File: pcc_pkg.sv
// Shared constants and types for the card configuration register block
package pcc_pkg;

	// Logical devices and bus decode
	localparam int          NUM_LDEV       = 4;
	localparam int          LDEV_W         = 2;
	localparam int          IDX_LSB        = 2;
	localparam int          IDX_MSB        = 9;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic        HRESP_OKAY     = 1'b0;

	// Register indices, byte address is four times the index
	localparam logic [7:0]  IDX_CFG_CTRL   = 8'h02;
	localparam logic [7:0]  IDX_WAKE       = 8'h03;
	localparam logic [7:0]  IDX_RES_DATA   = 8'h04;
	localparam logic [7:0]  IDX_STATUS     = 8'h05;
	localparam logic [7:0]  IDX_CSN        = 8'h06;
	localparam logic [7:0]  IDX_LDN        = 8'h07;
	localparam logic [7:0]  IDX_KEY_ENTER  = 8'h1F;
	localparam logic [7:0]  IDX_ACTIVATE   = 8'h30;
	localparam logic [7:0]  IDX_RANGE_CHK  = 8'h31;
	localparam logic [7:0]  IDX_BASE0_HI   = 8'h60;
	localparam logic [7:0]  IDX_BASE0_LO   = 8'h61;
	localparam logic [7:0]  IDX_BASE1_HI   = 8'h62;
	localparam logic [7:0]  IDX_BASE1_LO   = 8'h63;

	// Field positions
	localparam int          CTRL_SOFT_RST  = 0;
	localparam int          CTRL_WAIT_KEY  = 1;
	localparam int          CTRL_CLR_CSN   = 2;
	localparam int          ACT_BIT        = 0;
	localparam int          CHK_PASS_BIT   = 0;
	localparam int          CHK_EN_BIT     = 1;

	// Values
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [15:0] RC_PASS        = 16'h0055;
	localparam logic [15:0] RC_FAIL        = 16'h00AA;
	localparam logic [15:0] IO_ZERO        = 16'h0000;
	localparam int          IO_DEC_LSB     = 3;

	// Resource stream timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          RES_FETCH_NS   = 40;
	localparam int          RES_FETCH_CYC  = (RES_FETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RES_CNT_W      = 3;
	localparam int          RES_LEN        = 16;
	localparam int          RES_PTR_W      = 4;

	typedef enum logic [3:0] {
		PCC_WAIT_KEY = 4'b0001,
		PCC_SLEEP    = 4'b0010,
		PCC_ISOL     = 4'b0100,
		PCC_CONFIG   = 4'b1000
	} pcc_card_state_t;

	typedef struct packed {
		logic        act;
		logic [1:0]  chk;
		logic [15:0] base0;
		logic [15:0] base1;
	} pcc_ldev_t;

	typedef struct packed {
		logic        rd_n;
		logic [15:0] addr;
	} pcc_isa_in_t;

	localparam pcc_isa_in_t ISA_IDLE = '{rd_n: 1'b1, addr: 16'h0000};

	typedef struct packed {
		logic [RES_PTR_W-1:0] ptr;
		logic                 ready;
		logic [RES_CNT_W-1:0] cnt;
	} pcc_res_state_t;

endpackage : pcc_pkg

// File: pcc_resource_stream.sv
// Resource information byte stream with ready flag
`timescale 1ns/1ps
module pcc_resource_stream
	import pcc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       restart,
	input  wire logic       advance,
	// Stream
	output logic            ready,
	output logic [7:0]      data
);

	// Resource bytes, values arbitrary
	localparam logic [7:0] RES_ROM [RES_LEN] = '{
		8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h01,
		8'h5A, 8'h0A, 8'h10, 8'h15, 8'h47, 8'h01, 8'h79, 8'h00
	};
	localparam logic [RES_CNT_W-1:0] CNT_LOAD = RES_CNT_W'(RES_FETCH_CYC - 1);
	localparam logic [RES_PTR_W-1:0] PTR_LAST = RES_PTR_W'(RES_LEN - 1);
	localparam pcc_res_state_t       RES_RESET = '{ptr: '0, ready: 1'b1, cnt: '0};

	pcc_res_state_t q;
	pcc_res_state_t next_q;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_q = q;
		if (restart)
		begin
			next_q.ptr   = '0;                                    // [R7]
			next_q.ready = 1'b0;
			next_q.cnt   = CNT_LOAD;
		end
		else if (advance && q.ready)
		begin
			if (q.ptr != PTR_LAST)
				next_q.ptr = q.ptr + RES_PTR_W'(1);               // [R10]
			next_q.ready = 1'b0;
			next_q.cnt   = CNT_LOAD;
		end
		else if (!q.ready)
		begin
			if (q.cnt == '0)
				next_q.ready = 1'b1;                              // [R9]
			else
				next_q.cnt = q.cnt - RES_CNT_W'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= RES_RESET;
		else
			q <= next_q;
	end

	assign ready = q.ready;
	assign data  = RES_ROM[q.ptr];

endmodule : pcc_resource_stream

// File: pcc_isa_host.sv
// ISA host model that performs I/O reads on the card pins
`timescale 1ns/1ps
module pcc_isa_host
	import pcc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Read request from the bench
	input  wire logic        go,
	input  wire logic [15:0] addr,
	// Card pins
	output logic             io_rd_n,
	output logic [15:0]      io_addr
);
	// Released address lines hold the inverse of the requested address
	always_ff @(posedge clk)
	begin
		io_rd_n <= rst | !go;
		io_addr <= rst ? 16'h0000 : (go ? addr : ~addr);
	end
endmodule : pcc_isa_host

// File: pcc_card_config_regs_monitor.sv
// Assertions on the ports of the card configuration registers
`timescale 1ns/1ps
module pcc_card_config_regs_monitor
	import pcc_pkg::*;
(
	// Clock and reset
	input wire logic                CLK,
	input wire logic                RST,
	// AHB-Lite slave
	input wire logic                HSEL,
	input wire logic [31:0]         HADDR,
	input wire logic [1:0]          HTRANS,
	input wire logic                HWRITE,
	input wire logic [2:0]          HSIZE,
	input wire logic [31:0]         HWDATA,
	input wire logic                HREADY,
	input wire logic                HREADYOUT,
	input wire logic                HRESP,
	input wire logic [31:0]         HRDATA,
	// ISA pins
	input wire logic                IO_RD_N,
	input wire logic [15:0]         IO_ADDR,
	input wire logic [15:0]         IO_DATA,
	input wire logic                IO_DATA_OE,
	// Card status
	input wire logic [NUM_LDEV-1:0] DEV_ACTIVE,
	input wire logic [3:0]          CARD_STATE
);
	logic       wp;
	logic       rp;
	logic [7:0] wi;
	logic [7:0] num;

	// Data phase tracking and card number shadow
	always_ff @(posedge CLK)
	begin
		wp <= !RST && HSEL && HREADY && HTRANS[1] && HWRITE;
		rp <= !RST && HSEL && HREADY && HTRANS[1] && !HWRITE;
		wi <= HADDR[9:2];
		if (RST || (wp && wi == IDX_CFG_CTRL && HWDATA[CTRL_CLR_CSN]))
			num <= 8'h00;
		else if (wp && wi == IDX_CSN)
			num <= HWDATA[7:0];
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_wr(logic [7:0] idx);
		wp && wi == idx;
	endsequence
	sequence s_rd_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence

	property p_wait_key;
		s_wr(IDX_CFG_CTRL) ##0 HWDATA[CTRL_WAIT_KEY] |-> ##[1:3] CARD_STATE == PCC_WAIT_KEY;
	endproperty
	property p_wake;
		s_wr(IDX_WAKE) ##0 (CARD_STATE == PCC_SLEEP && HWDATA[7:0] == num)
			|-> ##[1:3] CARD_STATE == (num == 8'h00 ? PCC_ISOL : PCC_CONFIG);
	endproperty
	property p_soft_rst;
		s_wr(IDX_CFG_CTRL) ##0 HWDATA[CTRL_SOFT_RST] |-> ##[1:3] DEV_ACTIVE == '0;
	endproperty
	property p_rd_wait;
		rp |-> s_rd_wait;
	endproperty
	property p_rd_upper;
		rp |-> ##1 HRDATA[31:8] == '0;
	endproperty
	property p_oe_val;
		IO_DATA_OE |-> IO_DATA == RC_PASS || IO_DATA == RC_FAIL;
	endproperty
	property p_oe_idle;
		!IO_DATA_OE |-> IO_DATA == IO_ZERO;
	endproperty
	property p_oe_rise;
		$rose(IO_DATA_OE) |-> !$past(IO_RD_N) && !$past(IO_RD_N, 2);
	endproperty

	a_wait_key: assert property (p_wait_key)
		else $error("card did not return to wait for key");
	a_wake: assert property (p_wake)
		else $error("wake with matching number gave wrong state");
	a_soft_rst: assert property (p_soft_rst)
		else $error("soft reset left a device active");
	a_rd_wait: assert property (p_rd_wait)
		else $error("read data phase not one wait state");
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read data bits not zero");
	a_oe_val: assert property (p_oe_val)
		else $error("range check answer has wrong value");
	a_oe_idle: assert property (p_oe_idle)
		else $error("io data not zero while idle");
	a_oe_rise: assert property (p_oe_rise)
		else $error("range check answer without read strobe");
endmodule : pcc_card_config_regs_monitor

bind pcc_card_config_regs pcc_card_config_regs_monitor i_mon (.*);

// File: pcc_card_config_regs_test.sv
// Testbench for the card configuration registers
`timescale 1ns/1ps
module pcc_card_config_regs_test
	import pcc_pkg::*;
;
	logic        clk, rst, hsel, hwrite, go;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] isa_a;
	logic [7:0]  rd, b0, b1;
	wire         hreadyout, hresp, io_rd_n, io_data_oe;
	wire  [31:0] hrdata;
	wire  [15:0] io_addr, io_data;
	wire  [3:0]  dev_active, card_state;
	int          n_errors, compares;

	pcc_card_config_regs i_dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
		.IO_RD_N(io_rd_n), .IO_ADDR(io_addr), .IO_DATA(io_data),
		.IO_DATA_OE(io_data_oe), .DEV_ACTIVE(dev_active), .CARD_STATE(card_state));
	pcc_isa_host i_host (.clk(clk), .rst(rst), .go(go), .addr(isa_a),
		.io_rd_n(io_rd_n), .io_addr(io_addr));

	////////////////////////////////
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr  <= {22'h00_0000, idx, 2'b00};
		do @(posedge clk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, wd};
		do @(posedge clk); while (!hreadyout);
		rd = hrdata[7:0];
	endtask : xfer

	task rdc(input logic [7:0] idx, input logic [7:0] exp, input string nm);
		xfer(1'b0, idx, 8'h00);
		chk(nm, rd, exp);
		chk("hresp", hresp, HRESP_OKAY);
	endtask : rdc

	task res(output logic [7:0] b);
		do xfer(1'b0, IDX_STATUS, 8'h00); while (!rd[0]);
		xfer(1'b0, IDX_RES_DATA, 8'h00);
		b = rd;
	endtask : res

	task isa(input logic [15:0] a, input logic oe, input logic [15:0] d);
		go    <= 1'b1;
		isa_a <= a;
		repeat (8) @(posedge clk);
		chk("io_oe", io_data_oe, oe);
		chk("io_data", io_data, d);
		go <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : isa

	task test_done;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		test_done;
	end

	initial
	begin
		{hwrite, go, haddr, hwdata, htrans, isa_a} = '0;
		rst = 1'b1;
		hsel = 1'b1;
		hsize = 3'h2;
		n_errors = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(IDX_CSN, 8'h00, "card_num_rst");
		chk("state_rst", card_state, PCC_WAIT_KEY);
		xfer(1'b1, IDX_KEY_ENTER, 8'h00);
		xfer(1'b1, IDX_CSN, 8'h5A);
		rdc(IDX_CSN, 8'h5A, "card_num");
		xfer(1'b1, IDX_WAKE, 8'h5A);
		repeat (3) @(posedge clk);
		chk("state_cfg", card_state, PCC_CONFIG);
		xfer(1'b1, IDX_CFG_CTRL, 8'h02);
		repeat (3) @(posedge clk);
		chk("state_wfk", card_state, PCC_WAIT_KEY);
		rdc(IDX_CSN, 8'h5A, "card_num_kept");
		xfer(1'b1, IDX_KEY_ENTER, 8'h00);
		repeat (3) @(posedge clk);
		chk("state_sleep", card_state, PCC_SLEEP);
		xfer(1'b1, IDX_CFG_CTRL, 8'h04);
		rdc(IDX_CSN, 8'h00, "card_num_clr");
		xfer(1'b1, IDX_WAKE, 8'h00);
		repeat (3) @(posedge clk);
		chk("state_isol", card_state, PCC_ISOL);
		res(b0);
		res(b1);
		xfer(1'b1, IDX_WAKE, 8'hFF);
		res(b1);
		chk("res_restart", b1, b0);
		xfer(1'b1, IDX_RES_DATA, 8'hFF);
		rdc(IDX_WAKE, 8'h00, "wake_wo");
		xfer(1'b1, IDX_LDN, 8'h01);
		for (int i = 0; i < 4; i++)
			xfer(1'b1, IDX_BASE0_HI + 8'(i), 8'h11 * 8'(i + 1));
		for (int i = 0; i < 4; i++)
			rdc(IDX_BASE0_HI + 8'(i), 8'h11 * 8'(i + 1), "io_base");
		xfer(1'b1, IDX_ACTIVATE, 8'hFF);
		rdc(IDX_ACTIVATE, 8'h01, "act_rsvd");
		repeat (3) @(posedge clk);
		chk("dev_active", dev_active, 4'b0010);
		xfer(1'b1, IDX_LDN, 8'h00);
		rdc(IDX_BASE0_HI, 8'h00, "ldn0_base");
		xfer(1'b1, IDX_BASE0_HI, 8'h02);
		xfer(1'b1, IDX_BASE0_LO, 8'h20);
		xfer(1'b1, IDX_RANGE_CHK, 8'hFF);
		rdc(IDX_RANGE_CHK, 8'h03, "chk_rsvd");
		isa(16'h0224, 1'b1, RC_PASS);
		isa(16'h0230, 1'b0, IO_ZERO);
		xfer(1'b1, IDX_RANGE_CHK, 8'h02);
		isa(16'h0220, 1'b1, RC_FAIL);
		xfer(1'b1, IDX_RANGE_CHK, 8'h00);
		xfer(1'b1, IDX_ACTIVATE, 8'h01);
		xfer(1'b1, IDX_RANGE_CHK, 8'h03);
		isa(16'h0224, 1'b0, IO_ZERO);
		xfer(1'b1, IDX_CSN, 8'h33);
		xfer(1'b1, IDX_CFG_CTRL, 8'h01);
		repeat (3) @(posedge clk);
		chk("soft_rst_act", dev_active, 4'b0000);
		rdc(IDX_CSN, 8'h33, "soft_rst_num");
		rdc(IDX_RANGE_CHK, 8'h00, "soft_rst_chk");
		test_done;
	end
endmodule : pcc_card_config_regs_test
